// [hdl/hdltl_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none

module hdltl_ctrl
    import hdltl_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    // parallel register port
    input wire logic i_cs,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    // channel reset towards the hdlc
    output logic o_hdlc_rst,
    // enables from the hdlc control registers
    input wire logic i_receiver_enable_bit,
    input wire logic i_transmitter_enable_bit,
    // bit clock levels and the receive one-cycle tick enable
    input wire logic i_receive_bit_clock,
    input wire logic i_transmit_bit_clock,
    input wire logic i_rx_bit_tick,
    // serial lines
    input wire logic i_rx_line_data,
    input wire logic i_tx_packet_data,
    output logic o_rx_serial_in,
    // receiver comparator results and address set
    input wire logic i_rx_crc_ok,
    input wire logic i_rx_addr_ok,
    input wire logic [15:0] i_rx_addr_value,
    output logic [15:0] o_crc_corrupt_mask,
    // receiver byte stream
    input wire logic i_rxb_valid,
    input wire hdltl_byte_t i_rxb,
    output logic o_rxb_ready,
    // host fifo accesses
    input wire logic i_host_tx_write,
    input wire hdltl_byte_t i_host_tx_word,
    input wire logic i_host_rx_read,
    output hdltl_byte_t o_host_rx_word,
    // receive fifo
    output logic o_rxf_wr,
    output hdltl_byte_t o_rxf_din,
    input wire logic i_rxf_ready,
    output logic o_rxf_rd,
    input wire hdltl_byte_t i_rxf_q,
    // transmit fifo
    output logic o_txf_wr,
    output hdltl_byte_t o_txf_din,
    input wire logic i_txf_ready,
    output logic o_txf_rd,
    input wire hdltl_byte_t i_txf_q
);

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic zero_seen_reg;
    logic zero_seen_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [7:0] stat_word;
    wire ctrl_wr = i_cs & i_wr & (i_addr == HDLTL_CTRL_OFFSET);
    wire ctrl_rd = i_cs & i_rd & (i_addr == HDLTL_CTRL_OFFSET);
    wire stat_rd = i_cs & i_rd & (i_addr == HDLTL_STAT_OFFSET);
    wire wr_soft = i_wdata[HDLTL_CTRL_SOFT_RST];
    wire soft_rst = ctrl_reg[HDLTL_CTRL_SOFT_RST];
    wire rx_to_tx_loopback = ctrl_reg[HDLTL_CTRL_RX_TX_LOOP];
    wire crc_remainder_test = ctrl_reg[HDLTL_CTRL_CRC_TEST];
    wire fifo_redirect_test = ctrl_reg[HDLTL_CTRL_FIFO_TEST];
    wire address_match_test = ctrl_reg[HDLTL_CTRL_ADDR_TEST];
    wire tx_to_rx_loopback = ctrl_reg[HDLTL_CTRL_TX_RX_LOOP];

    // soft reset clears only on the second zero write in a row
    always_comb
    begin
        ctrl_next = ctrl_reg;
        zero_seen_next = zero_seen_reg;
        if (ctrl_wr)
        begin
            if (wr_soft)
            begin
                ctrl_next = i_wdata;
                zero_seen_next = 1'b0;
            end
            else if (soft_rst & ~zero_seen_reg)
            begin
                zero_seen_next = 1'b1;
            end
            else
            begin
                ctrl_next = i_wdata;
                zero_seen_next = 1'b0;
            end
        end
        // while held in reset the other bits fall back like a chip reset
        if (ctrl_next[HDLTL_CTRL_SOFT_RST])
        begin
            ctrl_next = HDLTL_CTRL_RESET;
            ctrl_next[HDLTL_CTRL_SOFT_RST] = 1'b1;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ctrl_reg <= HDLTL_CTRL_RESET;
            zero_seen_reg <= 1'b0;
            rdata_reg <= HDLTL_RDATA_RESET;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            zero_seen_reg <= zero_seen_next;
            rdata_reg <= rdata_next;
        end
    end

    assign o_hdlc_rst = i_rst | soft_rst;

    // reads only sample; nothing else moves on them
    assign rdata_next = ctrl_rd ? ctrl_reg :
                        stat_rd ? stat_word :
                        rdata_reg;
    assign o_rdata = rdata_reg;

    // ------------------------------------------------------------
    // serial test shifters
    // ------------------------------------------------------------
    logic [15:0] crc_sr_reg;
    logic [15:0] addr_sr_reg;
    logic [4:0] crc_cnt_reg;
    logic [4:0] addr_cnt_reg;

    // a shifter stops once it holds a whole comparison word
    function automatic logic shift_full(input logic [4:0] cnt);
        return (cnt == HDLTL_SHIFT_LEN);
    endfunction

    wire crc_shift = crc_remainder_test & i_rx_bit_tick &
                     ~shift_full(crc_cnt_reg);
    wire addr_shift = address_match_test & i_rx_bit_tick &
                      ~shift_full(addr_cnt_reg);

    // counters restart each time a test mode is left
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            crc_sr_reg <= HDLTL_SHIFT_RESET;
            crc_cnt_reg <= 5'h00;
        end
        else if (soft_rst | ~crc_remainder_test)
        begin
            crc_sr_reg <= HDLTL_SHIFT_RESET;
            crc_cnt_reg <= 5'h00;
        end
        else if (crc_shift)
        begin
            crc_sr_reg <= {crc_sr_reg[14:0], o_rx_serial_in};
            crc_cnt_reg <= crc_cnt_reg + 5'h01;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            addr_sr_reg <= HDLTL_SHIFT_RESET;
            addr_cnt_reg <= 5'h00;
        end
        else if (soft_rst | ~address_match_test)
        begin
            addr_sr_reg <= HDLTL_SHIFT_RESET;
            addr_cnt_reg <= 5'h00;
        end
        else if (addr_shift)
        begin
            addr_sr_reg <= {addr_sr_reg[14:0], o_rx_serial_in};
            addr_cnt_reg <= addr_cnt_reg + 5'h01;
        end
    end

    wire crc_aligned = shift_full(crc_cnt_reg);
    wire addr_aligned = shift_full(addr_cnt_reg);
    wire crc_match_test = crc_aligned &
                          (crc_sr_reg == HDLTL_CRC_EXPECT);
    wire addr_match_test = addr_aligned &
                           (addr_sr_reg == i_rx_addr_value);
    wire crc_match_flag = crc_remainder_test ? crc_match_test :
                          i_rx_crc_ok;
    wire address_match_flag = address_match_test ? addr_match_test :
                              i_rx_addr_ok;

    // bits where the shifted pattern differs from HDLTL_CRC_EXPECT flip the matching crc bits
    assign o_crc_corrupt_mask = crc_remainder_test ?
                                (crc_sr_reg ^ HDLTL_CRC_EXPECT) :
                                16'h0000;

    // ------------------------------------------------------------
    // status view and serial routing
    // ------------------------------------------------------------
    wire rx_gated_clock_view = i_receive_bit_clock &
                               i_receiver_enable_bit;
    wire tx_gated_clock_view = i_transmit_bit_clock &
                               i_transmitter_enable_bit;

    assign stat_word = {4'h0, rx_gated_clock_view, tx_gated_clock_view,
                        crc_match_flag, address_match_flag};

    // both enables are the host's duty in this mode
    assign o_rx_serial_in = tx_to_rx_loopback ? i_tx_packet_data :
                            i_rx_line_data;

    // ------------------------------------------------------------
    // fifo steering
    // ------------------------------------------------------------
    logic lb_in_ready;
    logic lb_out_valid;
    hdltl_byte_t lb_out_data;

    wire host_to_rx = fifo_redirect_test & i_host_tx_write;
    wire host_to_tx = ~fifo_redirect_test & i_host_tx_write;
    // host fifo write wins; the receiver simply waits a cycle
    wire rx_path_ok = i_rxf_ready & ~host_to_rx &
                      (~rx_to_tx_loopback | lb_in_ready);
    wire rx_take = i_rxb_valid & rx_path_ok;
    wire lb_push = rx_take & rx_to_tx_loopback;
    wire lb_pop_ok = i_txf_ready & ~host_to_tx;

    assign o_rxb_ready = rx_path_ok;
    assign o_rxf_wr = host_to_rx | rx_take;
    assign o_rxf_din = host_to_rx ? i_host_tx_word : i_rxb;
    // looped words drain into the tx fifo like host writes
    assign o_txf_wr = host_to_tx | (lb_out_valid & lb_pop_ok);
    assign o_txf_din = host_to_tx ? i_host_tx_word : lb_out_data;
    assign o_rxf_rd = i_host_rx_read & ~fifo_redirect_test;
    assign o_txf_rd = i_host_rx_read & fifo_redirect_test;

    // a stall on the tx fifo holds the word here instead of losing it
    hdltl_skid_buf u_loop_buf (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_flush(soft_rst),
        .i_valid(lb_push),
        .i_data(i_rxb),
        .o_ready(lb_in_ready),
        .o_valid(lb_out_valid),
        .i_ready(lb_pop_ok),
        .o_data(lb_out_data)
    );

    // ------------------------------------------------------------
    // host fifo read data
    // ------------------------------------------------------------
    hdltl_byte_t host_word_reg;
    hdltl_byte_t host_word_next;

    // tags of the tx fifo output show up in the read word
    assign host_word_next = o_txf_rd ? i_txf_q :
                            o_rxf_rd ? i_rxf_q :
                            host_word_reg;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            host_word_reg <= HDLTL_BYTE_RESET;
        end
        else
        begin
            host_word_reg <= host_word_next;
        end
    end

    assign o_host_rx_word = host_word_reg;

endmodule // hdltl_ctrl

`default_nettype wire

// [hdl/hdltl_pkg.sv]
package hdltl_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] HDLTL_CTRL_OFFSET = 8'h1B;
    localparam logic [7:0] HDLTL_STAT_OFFSET = 8'h1C;
    localparam logic [7:0] HDLTL_CTRL_RESET = 8'h00;
    localparam logic [7:0] HDLTL_RDATA_RESET = 8'h00;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int HDLTL_CTRL_SOFT_RST = 7;
    localparam int HDLTL_CTRL_RX_TX_LOOP = 6;
    localparam int HDLTL_CTRL_RSVD5 = 5;
    localparam int HDLTL_CTRL_RSVD4 = 4;
    localparam int HDLTL_CTRL_CRC_TEST = 3;
    localparam int HDLTL_CTRL_FIFO_TEST = 2;
    localparam int HDLTL_CTRL_ADDR_TEST = 1;
    localparam int HDLTL_CTRL_TX_RX_LOOP = 0;

    // ------------------------------------------------------------
    // status register fields
    // ------------------------------------------------------------
    localparam int HDLTL_STAT_RX_CLK = 3;
    localparam int HDLTL_STAT_TX_CLK = 2;
    localparam int HDLTL_STAT_CRC_OK = 1;
    localparam int HDLTL_STAT_ADDR_OK = 0;

    // ------------------------------------------------------------
    // serial test access
    // ------------------------------------------------------------
    localparam logic [4:0] HDLTL_SHIFT_LEN = 5'h10;
    localparam logic [15:0] HDLTL_CRC_EXPECT = 16'hF0B8;
    localparam logic [15:0] HDLTL_SHIFT_RESET = 16'h0000;

    // fifo word: data byte plus its packet tags
    typedef struct packed {
        logic eop;
        logic abort;
        logic [7:0] data;
    } hdltl_byte_t;

    localparam hdltl_byte_t HDLTL_BYTE_RESET = '{1'b0, 1'b0, 8'h00};

endpackage

// [hdl/hdltl_skid_buf.sv]
`timescale 1ns/10ps
`default_nettype none

module hdltl_skid_buf
    import hdltl_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_flush,
    input wire logic i_valid,
    input wire hdltl_byte_t i_data,
    output logic o_ready,
    output logic o_valid,
    input wire logic i_ready,
    output hdltl_byte_t o_data
);

    // ------------------------------------------------------------
    // two entries
    // ------------------------------------------------------------
    hdltl_byte_t mem_reg [2];
    logic [1:0] count_reg;
    logic [1:0] count_next;
    logic wr_ptr_reg;
    logic rd_ptr_reg;
    logic push;
    logic pop;

    assign o_ready = (count_reg != 2'h2);
    assign o_valid = (count_reg != 2'h0);
    assign o_data = mem_reg[rd_ptr_reg];
    assign push = i_valid & o_ready;
    assign pop = o_valid & i_ready;
    assign count_next = count_reg + {1'b0, push} - {1'b0, pop};

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            count_reg <= 2'h0;
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
        end
        else if (i_flush)
        begin
            count_reg <= 2'h0;
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            wr_ptr_reg <= wr_ptr_reg ^ push;
            rd_ptr_reg <= rd_ptr_reg ^ pop;
        end
    end

    // storage needs no reset; valid is held by the count
    always_ff @(posedge i_clk)
    begin
        if (push)
        begin
            mem_reg[wr_ptr_reg] <= i_data;
        end
    end

endmodule // hdltl_skid_buf

`default_nettype wire

// [sim/hdltl_ctrl_bench.sv]
`timescale 1ns/10ps
`default_nettype none

module hdltl_ctrl_bench
    import hdltl_pkg::*;
;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_cs = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_rx_bit_tick = 1'b0;
    logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
    logic i_receiver_enable_bit = 1'b0, i_transmitter_enable_bit = 1'b0;
    logic i_receive_bit_clock = 1'b0, i_transmit_bit_clock = 1'b0;
    logic i_rx_line_data = 1'b0, i_tx_packet_data = 1'b0, stall = 1'b0;
    logic i_rx_crc_ok = 1'b0, i_rx_addr_ok = 1'b0, i_rxb_valid = 1'b0;
    logic i_host_tx_write = 1'b0, i_host_rx_read = 1'b0;
    logic [15:0] i_rx_addr_value = 16'h5AC3, o_crc_corrupt_mask;
    hdltl_byte_t i_rxb = HDLTL_BYTE_RESET, i_host_tx_word = HDLTL_BYTE_RESET;
    hdltl_byte_t o_host_rx_word, o_rxf_din, i_rxf_q, o_txf_din, i_txf_q;
    logic o_hdlc_rst, o_rx_serial_in, o_rxb_ready, o_rxf_wr, i_rxf_ready;
    logic o_rxf_rd, o_txf_wr, i_txf_ready, o_txf_rd;
    int n_errors = 0;
    int total_checks = 0;
    always #25 i_clk = ~i_clk;
    hdltl_ctrl i_hdltl_ctrl (.i_clk(i_clk), .i_rst(i_rst), .i_cs(i_cs),
        .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata),
        .o_rdata(o_rdata), .o_hdlc_rst(o_hdlc_rst),
        .i_receiver_enable_bit(i_receiver_enable_bit),
        .i_transmitter_enable_bit(i_transmitter_enable_bit),
        .i_receive_bit_clock(i_receive_bit_clock),
        .i_transmit_bit_clock(i_transmit_bit_clock),
        .i_rx_bit_tick(i_rx_bit_tick), .i_rx_line_data(i_rx_line_data),
        .i_tx_packet_data(i_tx_packet_data), .o_rx_serial_in(o_rx_serial_in),
        .i_rx_crc_ok(i_rx_crc_ok), .i_rx_addr_ok(i_rx_addr_ok),
        .i_rx_addr_value(i_rx_addr_value),
        .o_crc_corrupt_mask(o_crc_corrupt_mask),
        .i_rxb_valid(i_rxb_valid), .i_rxb(i_rxb), .o_rxb_ready(o_rxb_ready),
        .i_host_tx_write(i_host_tx_write), .i_host_tx_word(i_host_tx_word),
        .i_host_rx_read(i_host_rx_read), .o_host_rx_word(o_host_rx_word),
        .o_rxf_wr(o_rxf_wr), .o_rxf_din(o_rxf_din), .i_rxf_ready(i_rxf_ready),
        .o_rxf_rd(o_rxf_rd), .i_rxf_q(i_rxf_q), .o_txf_wr(o_txf_wr),
        .o_txf_din(o_txf_din), .i_txf_ready(i_txf_ready),
        .o_txf_rd(o_txf_rd), .i_txf_q(i_txf_q));
    hdltl_fifo_model i_hdltl_fifo_model (.i_clk(i_clk), .i_rst(i_rst),
        .i_stall(stall), .i_rxf_rd(o_rxf_rd), .i_txf_rd(o_txf_rd),
        .o_rxf_ready(i_rxf_ready), .o_txf_ready(i_txf_ready),
        .o_rxf_q(i_rxf_q), .o_txf_q(i_txf_q));
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("Error at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic bus(input logic r, input logic [7:0] a,
        input logic [7:0] d);
        @(posedge i_clk);
        i_cs <= 1'b1;
        i_rd <= r;
        i_wr <= ~r;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_cs <= 1'b0;
        i_rd <= 1'b0;
        i_wr <= 1'b0;
        #1;
        if (r)
            chk(o_rdata, d);
    endtask
    // three extra ticks of inverted bits expose a shifter that never stops
    task automatic shift(input logic [15:0] p);
        for (int k = 15; k > -4; k--)
        begin
            @(posedge i_clk);
            i_rx_line_data <= (k < 0) ^ p[k & 15];
            i_rx_bit_tick <= 1'b1;
            @(posedge i_clk);
            i_rx_bit_tick <= 1'b0;
        end
        #1;
    endtask
    task automatic t_soft();
        bus(0, HDLTL_CTRL_OFFSET, 8'hC0);
        chk(o_hdlc_rst, 1'b1);
        bus(1, HDLTL_CTRL_OFFSET, 8'h80);
        bus(0, HDLTL_CTRL_OFFSET, 8'h00);
        bus(0, HDLTL_CTRL_OFFSET, 8'h80);
        bus(0, HDLTL_CTRL_OFFSET, 8'h00);
        chk(o_hdlc_rst, 1'b1);
        bus(0, HDLTL_CTRL_OFFSET, 8'h00);
        chk(o_hdlc_rst, 1'b0);
        bus(0, HDLTL_CTRL_OFFSET, 8'h80);
        i_rst <= 1'b1;
        @(posedge i_clk);
        i_rst <= 1'b0;
        #1;
        chk(o_hdlc_rst, 1'b0);
        bus(1, HDLTL_CTRL_OFFSET, 8'h00);
        $display("test soft reset done");
    endtask
    task automatic t_stat();
        @(posedge i_clk);
        i_transmitter_enable_bit <= 1'b1;
        i_receive_bit_clock <= 1'b1;
        i_transmit_bit_clock <= 1'b1;
        i_rx_addr_ok <= 1'b1;
        bus(1, HDLTL_STAT_OFFSET, 8'h05);
        bus(0, HDLTL_STAT_OFFSET, 8'hFF);
        bus(1, HDLTL_CTRL_OFFSET, 8'h00);
        i_receiver_enable_bit <= 1'b1;
        i_rx_addr_ok <= 1'b0;
        i_rx_crc_ok <= 1'b1;
        bus(1, HDLTL_STAT_OFFSET, 8'h0E);
        i_rx_crc_ok <= 1'b0;
        bus(0, HDLTL_CTRL_OFFSET, 8'h01);
        i_tx_packet_data <= 1'b1;
        i_receive_bit_clock <= 1'b0;
        i_transmit_bit_clock <= 1'b0;
        @(posedge i_clk);
        #1;
        chk(o_rx_serial_in, 1'b1);
        bus(0, HDLTL_CTRL_OFFSET, 8'h00);
        chk(o_rx_serial_in, 1'b0);
        $display("test status and loopback done");
    endtask
    task automatic t_shift(input logic [7:0] c, input logic [15:0] p);
        logic [7:0] e;
        e = (c == 8'h08) ? {6'h00, p == HDLTL_CRC_EXPECT, 1'b0} :
                           {7'h00, p == i_rx_addr_value};
        bus(0, HDLTL_CTRL_OFFSET, c);
        shift(p);
        if (c == 8'h08)
        begin
            chk(o_crc_corrupt_mask, p ^ HDLTL_CRC_EXPECT);
            bus(1, HDLTL_STAT_OFFSET, e);
        end
        else
            bus(1, HDLTL_STAT_OFFSET, e);
        bus(0, HDLTL_CTRL_OFFSET, 8'h00);
        bus(1, HDLTL_STAT_OFFSET, 8'h00);
        $display("test shift %h done", p);
    endtask
    task automatic t_loop();
        int n;
        logic acc;
        n = 0;
        bus(0, HDLTL_CTRL_OFFSET, 8'h40);
        stall <= 1'b1;
        i_rxb_valid <= 1'b1;
        i_rxb <= hdltl_byte_t'(10'h2A0);
        repeat (5)
        begin
            @(negedge i_clk);
            acc = (o_rxb_ready === 1'b1);
            @(posedge i_clk);
            if (acc)
                i_rxb <= hdltl_byte_t'(i_rxb + 10'h001);
            n += int'(acc);
        end
        stall <= 1'b0;
        chk(16'(n), 16'h0002);
        n = 0;
        // the held third word enters once the first pop frees a buffer slot
        repeat (6)
        begin
            @(negedge i_clk);
            acc = (o_rxb_ready === 1'b1);
            if (o_txf_wr === 1'b1 && i_txf_ready === 1'b1)
            begin
                if (n == 0)
                    chk(o_txf_din, 10'h2A0);
                n++;
            end
            @(posedge i_clk);
            if (acc)
                i_rxb_valid <= 1'b0;
        end
        chk(16'(n), 16'h0003);
        bus(0, HDLTL_CTRL_OFFSET, 8'h00);
        $display("test rx to tx loopback done");
    endtask
    task automatic t_fifo_redirect_test();
        bus(0, HDLTL_CTRL_OFFSET, 8'h04);
        i_host_tx_write <= 1'b1;
        i_host_tx_word <= hdltl_byte_t'(10'h15A);
        @(negedge i_clk);
        chk({o_rxf_wr, o_txf_wr, o_rxf_din}, 12'h95A);
        @(posedge i_clk);
        i_host_tx_write <= 1'b0;
        i_host_rx_read <= 1'b1;
        @(negedge i_clk);
        chk({o_rxf_rd, o_txf_rd}, 2'b01);
        @(posedge i_clk);
        i_host_rx_read <= 1'b0;
        #1;
        chk(o_host_rx_word, 10'h2C0);
        bus(0, HDLTL_CTRL_OFFSET, 8'h00);
        i_host_rx_read <= 1'b1;
        @(posedge i_clk);
        i_host_rx_read <= 1'b0;
        #1;
        chk(o_host_rx_word, 10'h130);
        i_host_tx_write <= 1'b1;
        @(negedge i_clk);
        chk({o_rxf_wr, o_txf_wr, o_txf_din}, 12'h55A);
        @(posedge i_clk);
        i_host_tx_write <= 1'b0;
        $display("test fifo redirect done");
    endtask
    initial
    begin
        #200000;
        n_errors++;
        end_sim();
    end
    initial
    begin
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        t_soft();
        t_stat();
        t_shift(8'h08, HDLTL_CRC_EXPECT);
        t_shift(8'h08, 16'h70B9);
        t_shift(8'h02, 16'h5AC3);
        t_shift(8'h02, 16'h5AC2);
        t_loop();
        t_fifo_redirect_test();
        end_sim();
    end
endmodule // hdltl_ctrl_bench

`default_nettype wire

// [sim/hdltl_ctrl_chk.sv]
`timescale 1ns/10ps
`default_nettype none

module hdltl_ctrl_chk
    import hdltl_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_cs,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic [7:0] o_rdata,
    input wire logic o_hdlc_rst,
    input wire logic [15:0] o_crc_corrupt_mask,
    input wire logic i_rxb_valid,
    input wire hdltl_byte_t i_rxb,
    input wire logic o_rxb_ready,
    input wire logic i_host_rx_read,
    input wire hdltl_byte_t o_host_rx_word,
    input wire logic o_rxf_wr,
    input wire hdltl_byte_t o_rxf_din,
    input wire logic i_rxf_ready,
    input wire logic o_rxf_rd,
    input wire hdltl_byte_t i_rxf_q,
    input wire logic o_txf_rd,
    input wire hdltl_byte_t i_txf_q
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    wire logic wr_ctrl = i_cs && i_wr && i_addr == HDLTL_CTRL_OFFSET;
    wire logic rd_stat = i_cs && i_rd && i_addr == HDLTL_STAT_OFFSET;
    property p_soft_set;
        wr_ctrl && i_wdata[7] |=> o_hdlc_rst;
    endproperty
    a_soft_set: assert property (p_soft_set) else $error("no reset");
    property p_soft_hold;
        o_hdlc_rst && !wr_ctrl |=> o_hdlc_rst;
    endproperty
    a_soft_hold: assert property (p_soft_hold) else $error("reset lost");
    property p_mask_rst;
        o_hdlc_rst |-> o_crc_corrupt_mask == 16'h0000;
    endproperty
    a_mask_rst: assert property (p_mask_rst) else $error("mask set");
    property p_stat_rsvd;
        rd_stat |=> o_rdata[7:4] == 4'h0;
    endproperty
    a_stat_rsvd: assert property (p_stat_rsvd) else $error("rsvd set");
    property p_rdata_hold;
        !(i_cs && i_rd) && !o_hdlc_rst |=> o_hdlc_rst || $stable(o_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("rdata");
    property p_rxb_copy;
        i_rxb_valid && o_rxb_ready |-> o_rxf_wr && o_rxf_din == i_rxb;
    endproperty
    a_rxb_copy: assert property (p_rxb_copy) else $error("rx copy");
    property p_rxb_ready;
        o_rxb_ready |-> i_rxf_ready;
    endproperty
    a_rxb_ready: assert property (p_rxb_ready) else $error("ready");
    // the word answers the fifo that was popped one cycle before
    property p_host_read;
        i_host_rx_read |-> (o_rxf_rd ^ o_txf_rd) ##1 o_host_rx_word ==
            ($past(o_txf_rd) ? $past(i_txf_q) : $past(i_rxf_q));
    endproperty
    a_host_read: assert property (p_host_read) else $error("read");
endmodule // hdltl_ctrl_chk

bind hdltl_ctrl hdltl_ctrl_chk i_hdltl_ctrl_chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_cs(i_cs), .i_wr(i_wr), .i_rd(i_rd),
    .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .o_hdlc_rst(o_hdlc_rst), .o_crc_corrupt_mask(o_crc_corrupt_mask),
    .i_rxb_valid(i_rxb_valid), .i_rxb(i_rxb), .o_rxb_ready(o_rxb_ready),
    .i_host_rx_read(i_host_rx_read), .o_host_rx_word(o_host_rx_word),
    .o_rxf_wr(o_rxf_wr), .o_rxf_din(o_rxf_din), .i_rxf_ready(i_rxf_ready),
    .o_rxf_rd(o_rxf_rd), .i_rxf_q(i_rxf_q), .o_txf_rd(o_txf_rd),
    .i_txf_q(i_txf_q));

`default_nettype wire

// [sim/hdltl_fifo_model.sv]
`timescale 1ns/10ps
`default_nettype none

module hdltl_fifo_model
    import hdltl_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_stall,
    input wire logic i_rxf_rd,
    input wire logic i_txf_rd,
    output logic o_rxf_ready,
    output logic o_txf_ready,
    output hdltl_byte_t o_rxf_q,
    output hdltl_byte_t o_txf_q
);
    logic [7:0] rx_head_reg;
    logic [7:0] tx_head_reg;
    // heads advance on every pop, so a stale word never passes
    assign o_rxf_ready = 1'b1;
    assign o_txf_ready = ~i_stall;
    assign o_rxf_q = '{1'b0, 1'b1, rx_head_reg};
    assign o_txf_q = '{1'b1, 1'b0, tx_head_reg};
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rx_head_reg <= 8'h30;
            tx_head_reg <= 8'hC0;
        end
        else
        begin
            rx_head_reg <= rx_head_reg + {7'h00, i_rxf_rd};
            tx_head_reg <= tx_head_reg + {7'h00, i_txf_rd};
        end
    end
endmodule // hdltl_fifo_model

`default_nettype wire
